// ==== rsx_pkg.sv ====
// package with operation codes, carriers and constants for the rsx datapath
// Summary of operation
// - rotate right through carry updates destination and carry only
// - destination bit 0 selects accumulator, 1 file
// - nibble exchange swaps halves, flags untouched
// - pin direction load copies accumulator, flags untouched
// - literal xor combines immediate with accumulator
// - file xor updates destination and zero only
package rsx_pkg;
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 5;
   localparam logic [7:0]  ACC_RST      = 8'h00;
   localparam logic [7:0]  DIR_RST      = 8'hFF;
   localparam logic        FLAG_RST     = 1'h0;
   localparam logic [4:0]  DIR_SEL_LO   = 5'h06;
   localparam logic [4:0]  DIR_SEL_HI   = 5'h07;
   localparam int          MSB_POS      = 7;
   localparam logic        DEST_ACC     = 1'h0;
   localparam logic        DEST_FILE    = 1'h1;

   typedef enum logic [2:0] {
      RSX_OP_NONE,
      RSX_OP_ROTR,
      RSX_OP_SWAP,
      RSX_OP_DIRLD,
      RSX_OP_XORL,
      RSX_OP_XORF
   } rsx_op_t;

   // one decoded instruction as it arrives from the decoder
   typedef struct packed {
      rsx_op_t     op;
      logic        dest;
      logic [4:0]  faddr;
      logic [7:0]  lit;
   } rsx_cmd_t;

   // one file register write request toward the register file
   typedef struct packed {
      logic        we;
      logic [4:0]  addr;
      logic [7:0]  data;
   } rsx_fwr_t;
endpackage : rsx_pkg

// ==== rsx_datapath.sv ====
// execution datapath for rotate, nibble exchange, direction load and xor
`timescale 1ns/1ps
`default_nettype none
module rsx_datapath (
   input  wire logic              I_CORE_CLK,
   input  wire logic              I_RST_N,
   input  wire logic              i_valid,
   input  var  rsx_pkg::rsx_cmd_t i_cmd,
   input  wire logic [7:0]        i_file_rdata,
   input  wire logic              i_carry,
   input  wire logic              i_zero,
   output logic [7:0]             o_acc,
   output logic                   o_carry,
   output logic                   o_zero,
   output var  rsx_pkg::rsx_fwr_t o_fwr,
   output logic [7:0]             o_dir6,
   output logic [7:0]             o_dir7,
   output logic                   o_done
);
   logic [7:0] acc_reg;
   logic       carry_reg;
   logic       zero_reg;
   logic [7:0] result_next;
   logic       carry_next;
   logic       zero_next;
   logic       to_dest;
   logic       xorf_hit;

   // all checks below run on the core clock and sleep during reset
   default clocking dp_cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (!I_RST_N);

   // command shapes that the checks start from
   sequence rotr_cmd_s;
      i_valid && i_cmd.op == rsx_pkg::RSX_OP_ROTR;
   endsequence
   sequence rotr_file_s;
      i_valid && i_cmd.op == rsx_pkg::RSX_OP_ROTR
      && i_cmd.dest == rsx_pkg::DEST_FILE;
   endsequence
   sequence swap_cmd_s;
      i_valid && i_cmd.op == rsx_pkg::RSX_OP_SWAP;
   endsequence
   sequence swap_acc_s;
      i_valid && i_cmd.op == rsx_pkg::RSX_OP_SWAP
      && i_cmd.dest == rsx_pkg::DEST_ACC;
   endsequence
   sequence xorl_cmd_s;
      i_valid && i_cmd.op == rsx_pkg::RSX_OP_XORL;
   endsequence
   sequence xorf_file_s;
      xorf_hit && i_cmd.dest == rsx_pkg::DEST_FILE;
   endsequence
   sequence xorf_acc_s;
      xorf_hit && i_cmd.dest == rsx_pkg::DEST_ACC;
   endsequence
   sequence dirld_cmd_s;
      i_valid && i_cmd.op == rsx_pkg::RSX_OP_DIRLD;
   endsequence
   sequence dir_lo_s;
      i_valid && i_cmd.op == rsx_pkg::RSX_OP_DIRLD
      && i_cmd.faddr == rsx_pkg::DIR_SEL_LO;
   endsequence
   sequence dir_hi_s;
      i_valid && i_cmd.op == rsx_pkg::RSX_OP_DIRLD
      && i_cmd.faddr == rsx_pkg::DIR_SEL_HI;
   endsequence
   sequence dir_bad_s;
      i_valid && i_cmd.op == rsx_pkg::RSX_OP_DIRLD
      && i_cmd.faddr != rsx_pkg::DIR_SEL_LO
      && i_cmd.faddr != rsx_pkg::DIR_SEL_HI;
   endsequence

   // result per operation; file operand is the current read data
   always_comb begin
      result_next = acc_reg;
      carry_next  = carry_reg;
      zero_next   = zero_reg;
      to_dest     = 1'h0;
      case (i_cmd.op)
         rsx_pkg::RSX_OP_ROTR: begin
            result_next = {carry_reg, i_file_rdata[7:1]};
            carry_next  = i_file_rdata[0];
            to_dest     = 1'h1;
         end
         rsx_pkg::RSX_OP_SWAP: begin
            result_next = {i_file_rdata[3:0], i_file_rdata[7:4]};
            to_dest     = 1'h1;
         end
         rsx_pkg::RSX_OP_XORL: begin
            result_next = acc_reg ^ i_cmd.lit;
         end
         rsx_pkg::RSX_OP_XORF: begin
            result_next = acc_reg ^ i_file_rdata;
            zero_next   = (result_next == 8'h00);
            to_dest     = 1'h1;
         end
         default: begin
            result_next = acc_reg;
         end
      endcase
   end

   assign xorf_hit = i_valid && (i_cmd.op == rsx_pkg::RSX_OP_XORF);

   // accumulator; literal xor always lands here, rotate, swap and file xor by destination
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         acc_reg <= rsx_pkg::ACC_RST;
      end else if (i_valid && (i_cmd.op == rsx_pkg::RSX_OP_XORL)) begin
         acc_reg <= result_next;
      end else if (i_valid && to_dest
                   && i_cmd.dest == rsx_pkg::DEST_ACC) begin
         acc_reg <= result_next;
      end
   end

   // accumulator destination checks
   swap_data_a: assert property (
      swap_acc_s |=>
      o_acc == {$past(i_file_rdata[3:0]), $past(i_file_rdata[7:4])})
      else $error("swap result wrong");
   xorl_acc_a: assert property (
      xorl_cmd_s |=>
      o_acc == ($past(o_acc) ^ $past(i_cmd.lit)) && !o_fwr.we)
      else $error("literal xor wrong");
   dest_acc_a: assert property (
      xorf_acc_s |=>
      o_acc == ($past(o_acc) ^ $past(i_file_rdata)) && !o_fwr.we)
      else $error("accumulator destination wrong");

   // status flags are loaded from the core's view, then kept current
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         carry_reg <= rsx_pkg::FLAG_RST;
         zero_reg  <= rsx_pkg::FLAG_RST;
      end else if (i_valid) begin
         // only rotate touches carry, only file xor touches zero
         carry_reg <= (i_cmd.op == rsx_pkg::RSX_OP_ROTR) ? carry_next
                                                         : carry_reg;
         zero_reg  <= xorf_hit ? zero_next : zero_reg;
      end else begin
         // idle: follow the status register owned by the core
         carry_reg <= i_carry;
         zero_reg  <= i_zero;
      end
   end

   // flag checks: each command moves only its own flag
   rot_carry_a: assert property (
      rotr_cmd_s |=> o_carry == $past(i_file_rdata[0]))
      else $error("rotate carry wrong");
   rot_zero_a: assert property (
      rotr_cmd_s |=> $stable(o_zero))
      else $error("rotate touched zero");
   swap_flags_a: assert property (
      swap_cmd_s |=> $stable(o_carry) && $stable(o_zero))
      else $error("swap touched flags");
   xorf_zero_a: assert property (
      xorf_hit |=>
      o_zero == ($past(o_acc) == $past(i_file_rdata)) && $stable(o_carry))
      else $error("file xor zero wrong");

   // file write back when destination bit is one
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         o_fwr <= '0;
      end else begin
         o_fwr.we   <= i_valid && to_dest
                       && (i_cmd.dest == rsx_pkg::DEST_FILE);
         o_fwr.addr <= i_cmd.faddr;
         o_fwr.data <= result_next;
      end
   end

   // file write back checks; a chained rotate must see the first carry
   rot_bit7_a: assert property (
      rotr_file_s |=>
      o_fwr.data == {$past(carry_reg), $past(i_file_rdata[7:1])})
      else $error("rotate result wrong");
   rot_chain_a: assert property (
      rotr_cmd_s ##1 rotr_cmd_s |=>
      o_fwr.data[7] == $past(i_file_rdata[0], 2))
      else $error("rotate chain carry wrong");
   dest_file_a: assert property (
      xorf_file_s |=> o_fwr.we && $stable(o_acc))
      else $error("file destination wrong");

   // direction registers; select other than 6 or 7 is ignored
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         o_dir6 <= rsx_pkg::DIR_RST;
         o_dir7 <= rsx_pkg::DIR_RST;
      end else if (i_valid && i_cmd.op == rsx_pkg::RSX_OP_DIRLD) begin
         if (i_cmd.faddr == rsx_pkg::DIR_SEL_LO) begin
            o_dir6 <= acc_reg;
         end else if (i_cmd.faddr == rsx_pkg::DIR_SEL_HI) begin
            o_dir7 <= acc_reg;
         end
      end
   end

   // direction register checks
   dir_load_a: assert property (
      dir_lo_s |=> o_dir6 == $past(o_acc) && $stable(o_carry))
      else $error("direction load wrong");
   dir_hi_a: assert property (
      dir_hi_s |=> o_dir7 == $past(o_acc) && $stable(o_dir6))
      else $error("upper direction load wrong");
   dir_other_a: assert property (
      dir_bad_s |=> $stable(o_dir6) && $stable(o_dir7))
      else $error("direction select ignored wrong");
   dir_flags_a: assert property (
      dirld_cmd_s |=> $stable(o_acc) && $stable(o_zero) && $stable(o_carry))
      else $error("direction load touched state");

   // completion pulse one cycle after the command
   always_ff @(posedge I_CORE_CLK) begin
      if (!I_RST_N) begin
         o_done <= 1'b0;
      end else begin
         o_done <= i_valid && (i_cmd.op != rsx_pkg::RSX_OP_NONE);
      end
   end

   assign o_acc   = acc_reg;
   assign o_carry = carry_reg;
   assign o_zero  = zero_reg;
endmodule : rsx_datapath
`default_nettype wire

// ==== rotate_swap_xor_ops_test.sv ====
// self-checking bench for the rsx execution datapath
`timescale 1ns/1ps
`default_nettype none
module rotate_swap_xor_ops_test;
   logic              clk   = 1'h0;
   logic              rst_n = 1'h0;
   logic              valid = 1'h0;
   rsx_pkg::rsx_cmd_t cmd   = '0;
   logic [7:0]        rdata = 8'h00;
   logic              cin   = 1'h0;
   logic              zin   = 1'h0;
   logic [7:0]        acc;
   logic [7:0]        dir6;
   logic [7:0]        dir7;
   logic              carry;
   logic              zero;
   logic              done;
   rsx_pkg::rsx_fwr_t fwr;
   int                n_fail    = 0;
   int                tests_run = 0;
   int                cycles    = 0;

   // 100 MHz core clock
   always #5 clk = ~clk;

   rsx_datapath i_rsx_datapath (.I_CORE_CLK(clk), .I_RST_N(rst_n),
      .i_valid(valid), .i_cmd(cmd), .i_file_rdata(rdata), .i_carry(cin),
      .i_zero(zin), .o_acc(acc), .o_carry(carry), .o_zero(zero),
      .o_fwr(fwr), .o_dir6(dir6), .o_dir7(dir7), .o_done(done));

   // whole run needs under 30 cycles, so 3000 means a hang
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         finish_test();
      end
   end

   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk

   // one command; valid stays up so calls may run back to back
   task op(input rsx_pkg::rsx_op_t o, input logic d, input logic [4:0] a,
           input logic [7:0] l, input logic [7:0] rd);
      valid = 1'h1;
      cmd   = '{o, d, a, l};
      rdata = rd;
      @(posedge clk);
      #1;
   endtask : op

   task idle(input int n);
      valid = 1'h0;
      repeat (n) @(posedge clk);
      #1;
   endtask : idle

   // flags only follow the core inputs while no command runs
   task flags(input logic c, input logic z);
      cin = c;
      zin = z;
      idle(2);
   endtask : flags

   task t_xor();
      op(rsx_pkg::RSX_OP_XORL, 1'h1, 5'h00, 8'hA5, 8'h00);
      chk("acc", 8'hA5, acc);
      op(rsx_pkg::RSX_OP_XORL, 1'h0, 5'h00, 8'hFF, 8'h00);
      chk("acc", 8'h5A, acc);
      chk("done", 8'h01, done);
      flags(1'h1, 1'h0);
      cin = 1'h0; // core carry moves while busy; held carry must win
      op(rsx_pkg::RSX_OP_XORF, 1'h0, 5'h02, 8'h00, 8'h5A);
      chk("acc", 8'h00, acc);
      chk("zero", 8'h01, zero);
      chk("carry", 8'h01, carry);
      chk("we", 8'h00, fwr.we);
      op(rsx_pkg::RSX_OP_XORF, 1'h1, 5'h1F, 8'h00, 8'h0F);
      chk("we", 8'h01, fwr.we);
      chk("addr", 8'h1F, fwr.addr);
      chk("data", 8'h0F, fwr.data);
      chk("acc", 8'h00, acc);
      chk("zero", 8'h00, zero);
      idle(1);
      chk("done", 8'h00, done);
      chk("we", 8'h00, fwr.we);
      $display("xor test ended");
   endtask : t_xor

   // back to back rotates: the second sees the carry of the first
   task t_rotr();
      flags(1'h1, 1'h1);
      zin = 1'h0; // zero must not follow the core during rotates
      op(rsx_pkg::RSX_OP_ROTR, 1'h1, 5'h03, 8'h00, 8'h02);
      chk("data", 8'h81, fwr.data);
      chk("addr", 8'h03, fwr.addr);
      chk("carry", 8'h00, carry);
      chk("zero", 8'h01, zero);
      op(rsx_pkg::RSX_OP_ROTR, 1'h0, 5'h03, 8'h00, 8'h03);
      chk("acc", 8'h01, acc);
      chk("carry", 8'h01, carry);
      chk("we", 8'h00, fwr.we);
      $display("rotate test ended");
   endtask : t_rotr

   task t_swap();
      flags(1'h0, 1'h1);
      cin = 1'h1; // both core flags move; swap must keep the held ones
      zin = 1'h0;
      op(rsx_pkg::RSX_OP_SWAP, 1'h0, 5'h00, 8'h00, 8'h3C);
      chk("acc", 8'hC3, acc);
      chk("carry", 8'h00, carry);
      chk("zero", 8'h01, zero);
      op(rsx_pkg::RSX_OP_SWAP, 1'h1, 5'h05, 8'h00, 8'hA1);
      chk("data", 8'h1A, fwr.data);
      chk("acc", 8'hC3, acc);
      $display("swap test ended");
   endtask : t_swap

   // select 5 must leave both direction registers alone
   task t_dir();
      op(rsx_pkg::RSX_OP_DIRLD, 1'h0, 5'h06, 8'h00, 8'h00);
      chk("dir6", 8'hC3, dir6);
      chk("dir7", 8'hFF, dir7);
      op(rsx_pkg::RSX_OP_XORL, 1'h0, 5'h00, 8'h96, 8'h00);
      op(rsx_pkg::RSX_OP_DIRLD, 1'h0, 5'h07, 8'h00, 8'h00);
      chk("dir7", 8'h55, dir7);
      chk("carry", 8'h00, carry);
      op(rsx_pkg::RSX_OP_DIRLD, 1'h0, 5'h05, 8'h00, 8'h00);
      chk("dir6", 8'hC3, dir6);
      chk("dir7", 8'h55, dir7);
      chk("done", 8'h01, done);
      $display("direction test ended");
   endtask : t_dir

   task finish_test();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   // reset for 8 cycles, check reset values, then run the scenarios
   initial begin
      repeat (8) @(posedge clk);
      #1;
      chk("acc", 8'h00, acc);
      chk("dir6", 8'hFF, dir6);
      chk("dir7", 8'hFF, dir7);
      chk("carry", 8'h00, carry);
      chk("zero", 8'h00, zero);
      chk("done", 8'h00, done);
      chk("we", 8'h00, fwr.we);
      $display("reset test ended");
      rst_n = 1'h1;
      t_xor();
      t_rotr();
      t_swap();
      t_dir();
      finish_test();
   end
endmodule : rotate_swap_xor_ops_test
`default_nettype wire
